/* logic/sptq_pkg.sv */
// constants and types shared by the spi transmit queue and fault logic
// What this block does
// - transmit data is double buffered; controller starts queued byte right after the current one
// - data write loads buffer and clears tx_empty_flag; moving it to shifter sets it
// - finished byte goes to receive register and sets rx_full_flag; status then data read clears
// - without a new byte the shifter resends what it last held
// - idle end with empty buffer sets tx_empty_flag within two bus cycles of the load
// - a target mid-transfer loads the shifter only after the transfer completes
// - overrun_flag sets if receive data still unread at the seventh sample strobe
// - during overrun new bytes are dropped, rx_full_flag untouched, old byte kept
// - status read then data read clears overrun_flag
// - one irq: rx_full plus overrun and conflict gated by error_irq_enable
// - controller_select drives clock and mosi as outputs, else miso is the output
// - select_conflict_flag only sets while conflict_detect_enable; clearing enable keeps flag
// - controller select low: flag, irq, clear enable, set tx_empty, reset counter, release pins
// - target flags conflict when select rises during a transfer, framed per clock phase
// - phase 0 select then deselect flags conflict; phase 1 without clocks does not
// - conflict leaves controller_select; controller_select ignored while module disabled
// - target conflict only flags and requests irq; software may abort by disabling
// - deselected target floats miso and ignores every clock edge
// - status read with flag then control write clears conflict unless a conflict event hits in that same cycle
// - disabled: tx_empty set, transfer aborted, shifter and counter cleared, pins released
package sptq_pkg;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam int         CTL_RXIE  = 7;
	localparam int         CTL_CSEL  = 5;
	localparam int         CTL_CLOCK_POLARITY_SELECT  = 4;
	localparam int         CTL_CLOCK_PHASE_SELECT  = 3;
	localparam int         CTL_EN    = 1;
	localparam int         ST_RXF    = 7;
	localparam int         ST_ERROR_IRQ_ENABLE  = 6;
	localparam int         ST_OVR    = 5;
	localparam int         ST_CONF   = 4;
	localparam int         ST_TXE    = 3;
	localparam int         ST_CDE    = 2;
	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [2:0] OVR_SAMP  = 3'h6;
	localparam logic [7:0] HALF_DEF  = 8'h04;
	localparam logic       TXE_RST   = 1'b1;
	localparam logic       SS_RST    = 1'b1;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b01,
		PH_BUSY = 2'b10
	} sptq_phase_e;

	typedef struct packed {
		logic rx_irq_en;
		logic err_irq_en;
		logic conf_det_en;
		logic csel;
		logic clock_polarity_select;
		logic clock_phase_select;
		logic en;
	} sptq_ctrl_s;

	typedef struct packed {
		logic ss_n;
		logic sck;
		logic mosi;
		logic miso;
	} sptq_pin_in_s;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
	} sptq_pin_out_s;

	typedef struct packed {
		sptq_ctrl_s  ctl;
		sptq_phase_e phase;
		logic        tx_empty;
		logic        rx_full;
		logic        overrun;
		logic        conflict;
		logic        buf_full;
		logic        arm_rx;
		logic        arm_ovr;
		logic        arm_conf;
		logic        sck_ff;
		logic        sck_prev;
		logic        ss_prev;
		logic        rx_latch;
		logic [7:0]  tx_buf;
		logic [7:0]  shift;
		logic [7:0]  rx_data;
		logic [7:0]  div_cnt;
		logic [3:0]  edge_cnt;
		logic [31:0] prdata;
	} sptq_state_s;
endpackage

/* logic/sptq_sync.sv */
// two flop synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none
module sptq_sync #(
	parameter int W = 4
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_ff;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_ff <= 1'b1;
					q[i]    <= 1'b1;
				end else begin
					meta_ff <= d[i];
					q[i]    <= meta_ff;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* logic/sptq_core.sv */
// spi transmit queue, receive flags and select conflict logic with apb registers
`timescale 1ns/100ps
`default_nettype none
module sptq_core
	import sptq_pkg::*;
#(
	parameter logic [7:0] HALF_DIV = HALF_DEF
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output var  logic [31:0]   prdata,
	output var  logic          pready,
	output var  logic          pslverr,
	input  wire sptq_pin_in_s  pin_i,
	output var  sptq_pin_out_s pin_o,
	output var  logic          irq
);
	sptq_state_s  s;
	sptq_state_s  n;
	sptq_pin_in_s si;
	logic [3:0]   sync_q;

	sptq_sync #(
		.W(4)
	) u_sync (
		.pclk   (pclk),
		.presetn(presetn),
		.d      (pin_i),
		.q      (sync_q)
	);
	assign si = sptq_pin_in_s'(sync_q);

	logic       hit;
	logic       acc;
	logic       setup;
	logic       ctl_mode;
	logic       tgt_mode;
	logic       busy;
	logic       int_edge;
	logic       sck_new;
	logic       edge_ok;
	logic       lead;
	logic       samp;
	logic       shft;
	logic       last;
	logic       rx_bit;
	logic       ss_fall;
	logic       ss_rise;
	logic       conf_evt;
	logic       conf_cond;
	logic [7:0] rx_byte;
	logic [7:0] stat_val;
	logic [7:0] ctrl_val;
	logic [7:0] rd_val;

	assign hit   = (paddr == ADDR_DATA) || (paddr == ADDR_STAT) || (paddr == ADDR_CTRL);
	assign acc   = psel && penable;
	assign setup = psel && !penable;

	// controller_select means nothing while disabled
	assign ctl_mode = s.ctl.en && s.ctl.csel;
	assign tgt_mode = s.ctl.en && !s.ctl.csel;
	assign busy     = (s.phase == PH_BUSY);

	always_comb begin
		stat_val           = 8'h00;
		stat_val[ST_RXF]   = s.rx_full;
		stat_val[ST_ERROR_IRQ_ENABLE] = s.ctl.err_irq_en;
		stat_val[ST_OVR]   = s.overrun;
		stat_val[ST_CONF]  = s.conflict;
		stat_val[ST_TXE]   = s.tx_empty;
		stat_val[ST_CDE]   = s.ctl.conf_det_en;
		ctrl_val           = 8'h00;
		ctrl_val[CTL_RXIE] = s.ctl.rx_irq_en;
		ctrl_val[CTL_CSEL] = s.ctl.csel;
		ctrl_val[CTL_CLOCK_POLARITY_SELECT] = s.ctl.clock_polarity_select;
		ctrl_val[CTL_CLOCK_PHASE_SELECT] = s.ctl.clock_phase_select;
		ctrl_val[CTL_EN]   = s.ctl.en;
		case (paddr)
			ADDR_DATA: rd_val = s.rx_data;
			ADDR_STAT: rd_val = stat_val;
			ADDR_CTRL: rd_val = ctrl_val;
			default:   rd_val = 8'h00;
		endcase
	end

	always_comb begin
		n          = s;
		n.sck_prev = si.sck;
		n.ss_prev  = si.ss_n;
		ss_fall    = s.ss_prev && !si.ss_n;
		ss_rise    = !s.ss_prev && si.ss_n;
		rx_byte    = 8'h00;

		// register side first so that hardware sets below win over clears
		if (setup) begin
			n.prdata = {24'h000000, rd_val};
		end
		if (acc && hit && !pwrite) begin
			if (paddr == ADDR_STAT) begin
				n.arm_rx   = s.prdata[ST_RXF];
				n.arm_ovr  = s.prdata[ST_OVR];
				n.arm_conf = s.prdata[ST_CONF];
			end
			if (paddr == ADDR_DATA) begin
				if (s.arm_rx) begin
					n.rx_full = 1'b0;
				end
				if (s.arm_ovr) begin
					n.overrun = 1'b0;
				end
				n.arm_rx  = 1'b0;
				n.arm_ovr = 1'b0;
			end
		end

		// controller clock divider
		int_edge = ctl_mode && busy && (s.div_cnt == HALF_DIV - 8'h01);
		if (ctl_mode && busy) begin
			n.div_cnt = int_edge ? 8'h00 : s.div_cnt + 8'h01;
		end
		if (int_edge) begin
			n.sck_ff = !s.sck_ff;
		end
		sck_new = ctl_mode ? !s.sck_ff : si.sck;
		lead    = (sck_new != s.ctl.clock_polarity_select);
		rx_bit  = ctl_mode ? si.miso : si.mosi;

		// deselected target sees no edges; phase 0 target needs a select fall first
		if (ctl_mode) begin
			edge_ok = int_edge;
		end else begin
			edge_ok = tgt_mode && !si.ss_n && (si.sck != s.sck_prev) &&
				(busy || (s.ctl.clock_phase_select && lead));
		end
		samp = edge_ok && (s.ctl.clock_phase_select ? !lead : lead);
		shft = edge_ok && (s.ctl.clock_phase_select ? (lead && s.edge_cnt != 4'h0) : !lead);
		last = edge_ok && (s.edge_cnt == LAST_EDGE);

		// phase 0 target transfer opens on select fall
		if (tgt_mode && !busy && !s.ctl.clock_phase_select && ss_fall) begin
			n.phase    = PH_BUSY;
			n.edge_cnt = 4'h0;
		end

		if (edge_ok) begin
			n.phase    = PH_BUSY;
			n.edge_cnt = s.edge_cnt + 4'h1;
		end
		if (samp) begin
			n.rx_latch = rx_bit;
			if (s.edge_cnt[3:1] == OVR_SAMP && s.rx_full) begin
				n.overrun = 1'b1;
			end
		end
		if (shft) begin
			n.shift = {s.shift[6:0], s.rx_latch};
		end
		if (last) begin
			rx_byte    = s.ctl.clock_phase_select ? {s.shift[6:0], rx_bit} : {s.shift[6:0], s.rx_latch};
			// received byte stays in the shifter and goes out again if nothing is queued
			n.shift    = rx_byte;
			n.phase    = PH_IDLE;
			n.edge_cnt = 4'h0;
			if (!n.overrun) begin
				n.rx_data = rx_byte;
				n.rx_full = 1'b1;
			end
		end

		// buffer to shifter only between transfers
		if (s.ctl.en && !busy && s.buf_full) begin
			n.shift    = s.tx_buf;
			n.buf_full = 1'b0;
			n.tx_empty = 1'b1;
			if (ctl_mode) begin
				n.phase   = PH_BUSY;
				n.div_cnt = 8'h00;
			end
		end

		if (acc && hit && pwrite) begin
			if (paddr == ADDR_DATA && s.ctl.en) begin
				n.tx_buf   = pwdata[7:0];
				n.buf_full = 1'b1;
				n.tx_empty = 1'b0;
			end
			if (paddr == ADDR_STAT) begin
				n.ctl.err_irq_en  = pwdata[ST_ERROR_IRQ_ENABLE];
				n.ctl.conf_det_en = pwdata[ST_CDE];
			end
			if (paddr == ADDR_CTRL) begin
				n.ctl.rx_irq_en = pwdata[CTL_RXIE];
				n.ctl.csel      = pwdata[CTL_CSEL];
				n.ctl.clock_polarity_select      = pwdata[CTL_CLOCK_POLARITY_SELECT];
				n.ctl.clock_phase_select      = pwdata[CTL_CLOCK_PHASE_SELECT];
				n.ctl.en        = pwdata[CTL_EN];
			end
		end

		// conflict detection, only while enabled for it
		conf_evt  = s.ctl.conf_det_en &&
			((ctl_mode && !si.ss_n) || (tgt_mode && busy && ss_rise));
		conf_cond = conf_evt || (s.ctl.conf_det_en && ctl_mode && !si.ss_n);

		if (acc && hit && pwrite && paddr == ADDR_CTRL) begin
			if (s.arm_conf && !conf_cond) begin
				n.conflict = 1'b0;
			end
			n.arm_conf = 1'b0;
		end

		if (conf_evt) begin
			n.conflict = 1'b1;
			if (ctl_mode) begin
				// controller_select is kept so software can tell the two cases apart
				n.ctl.en = 1'b0;
			end
			// a target keeps running; software disables it to abort
		end

		// partial reset while disabled; control bits and sticky flags survive
		if (!n.ctl.en) begin
			n.tx_empty = 1'b1;
			n.buf_full = 1'b0;
			n.phase    = PH_IDLE;
			n.shift    = 8'h00;
			n.edge_cnt = 4'h0;
			n.div_cnt  = 8'h00;
			n.sck_ff   = n.ctl.clock_polarity_select;
		end else if (!busy && !ctl_mode) begin
			n.sck_ff = n.ctl.clock_polarity_select;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s          <= '0;
			s.phase    <= PH_IDLE;
			s.tx_empty <= TXE_RST;
			s.ss_prev  <= SS_RST;
		end else begin
			s <= n;
		end
	end

	assign prdata  = s.prdata;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;

	// pins go back to port control while disabled
	always_comb begin
		pin_o         = '0;
		pin_o.sck_o   = ctl_mode ? s.sck_ff : s.ctl.clock_polarity_select;
		pin_o.sck_oe  = ctl_mode;
		pin_o.mosi_o  = s.shift[7];
		pin_o.mosi_oe = ctl_mode;
		pin_o.miso_o  = s.shift[7];
		pin_o.miso_oe = tgt_mode && !si.ss_n;
	end

	// overrun and conflict share the single error enable
	assign irq = (s.rx_full && s.ctl.rx_irq_en) ||
		(s.ctl.err_irq_en && (s.overrun || s.conflict));
endmodule
`default_nettype wire

/* tb/sptq_core_assertions.sv */
// port-level checks for the spi queue and fault block
`timescale 1ns/100ps
`default_nettype none
module sptq_core_assertions
	import sptq_pkg::*;
#(
	parameter logic [7:0] HALF_DIV = HALF_DEF
) (
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire sptq_pin_in_s  pin_i,
	input wire sptq_pin_out_s pin_o,
	input wire logic          irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic ctl_wr;
	logic st_rd;
	assign ctl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
	assign st_rd  = psel && penable && !pwrite && paddr == ADDR_STAT;
	a_oe_exclusive: assert property (!(pin_o.sck_oe && pin_o.miso_oe))
		else $error("clock and miso both driven");
	a_pins_paired: assert property (pin_o.mosi_oe == pin_o.sck_oe)
		else $error("mosi and clock enables differ");
	a_ctrl_drive: assert property (ctl_wr && pwdata[CTL_EN] && pwdata[CTL_CSEL] && pin_i.ss_n |-> ##[1:3] pin_o.sck_oe)
		else $error("controller pins not driven");
	a_off_release: assert property (ctl_wr && !pwdata[CTL_EN] |-> ##[1:3] !(pin_o.sck_oe || pin_o.mosi_oe || pin_o.miso_oe))
		else $error("pins kept while disabled");
	a_deselect_float: assert property (pin_i.ss_n [*4] |-> !pin_o.miso_oe)
		else $error("miso driven while deselected");
	a_err_irq: assert property (st_rd && prdata[ST_ERROR_IRQ_ENABLE] && (prdata[ST_OVR] || prdata[ST_CONF]) |-> irq)
		else $error("error flag without irq");
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access left waiting");
	a_unmapped_err: assert property (psel && penable && paddr > ADDR_CTRL |-> pslverr)
		else $error("unmapped access without error");
	a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'b00 && paddr <= ADDR_CTRL |-> !pslverr)
		else $error("mapped access flagged");
endmodule
bind sptq_core sptq_core_assertions #(.HALF_DIV(HALF_DIV)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .irq(irq));
`default_nettype wire

/* tb/sptq_partner.sv */
// remote spi party: controller for a target dut, target for a controller dut
`timescale 1ns/100ps
`default_nettype none
module sptq_partner (
	input  wire logic dut_sck,
	input  wire logic dut_mosi,
	input  wire logic dut_miso,
	output var  logic ss_n,
	output var  logic sck,
	output var  logic mosi,
	output var  logic miso
);
	logic [7:0] tsh = 8'h00;
	logic [7:0] rsh = 8'h00;
	initial begin
		ss_n = 1'b1;
		sck  = 1'b0;
		mosi = 1'b0;
	end
	// target role, phase 0; refill bits keep miso moving after the byte
	always @(posedge dut_sck) rsh <= {rsh[6:0], dut_mosi};
	always @(negedge dut_sck) tsh <= {tsh[6:0], ~tsh[0]};
	assign miso = tsh[7];
	// controller role; the 5 ns offset keeps link edges off the bus clock edges
	task automatic xfer(input logic [7:0] tx, input logic clock_phase_select, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		#5;
		ss_n = 1'b0;
		mosi = tx[7];
		#200;
		for (int i = 0; i < nb; i++) begin
			if (clock_phase_select) begin
				mosi = tx[7];
				tx = tx << 1;
			end
			sck = 1'b1;
			if (!clock_phase_select) rx = {rx[6:0], dut_miso};
			#100;
			sck = 1'b0;
			if (clock_phase_select) rx = {rx[6:0], dut_miso};
			else tx = tx << 1;
			if (!clock_phase_select) mosi = tx[7];
			#100;
		end
		ss_n = 1'b1;
		mosi = ~mosi;
		#200;
	endtask
endmodule
`default_nettype wire

/* tb/spi_tx_queue_and_fault_logic_bench.sv */
// self-checking bench for the spi queue and fault block
`timescale 1ns/100ps
`default_nettype none
module spi_tx_queue_and_fault_logic_bench;
	import sptq_pkg::*;
	logic          pclk;
	logic          presetn;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [7:0]    paddr;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	sptq_pin_in_s  pin_i;
	sptq_pin_out_s pin_o;
	logic          irq;
	logic          ss_n;
	logic          sck;
	logic          mosi;
	logic          miso;
	logic [7:0]    rx;
	logic [31:0]   rdata;
	int            n_errors;
	int            samples_checked;
	assign pin_i = '{ss_n, pin_o.sck_oe ? pin_o.sck_o : sck, pin_o.mosi_oe ? pin_o.mosi_o : mosi, miso};
	sptq_core #(.HALF_DIV(8'h04)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_i(pin_i), .pin_o(pin_o), .irq(irq));
	// a released miso shows the inverse of its last value, so late drive is caught
	sptq_partner p (.dut_sck(pin_o.sck_o), .dut_mosi(pin_o.mosi_o),
		.dut_miso(pin_o.miso_oe ? pin_o.miso_o : !pin_o.miso_o), .ss_n(ss_n),
		.sck(sck), .mosi(mosi), .miso(miso));
	task automatic test_done();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			test_done();
		end
		// read data is taken at the edge that completes the access
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask
	task automatic sel_pulse();
		p.ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		p.ss_n <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic t_regs();
		rd(ADDR_STAT, 32'h08);
		rd(ADDR_CTRL, 32'h00);
		apb(1'b1, 8'h0c, 32'hff);
		rd(8'h0c, 32'h00);
		apb(1'b1, ADDR_DATA, 32'h5a);
		rd(ADDR_STAT, 32'h08);
	endtask
	task automatic t_target();
		apb(1'b1, ADDR_STAT, 32'h40);
		apb(1'b1, ADDR_CTRL, 32'h02);
		apb(1'b1, ADDR_DATA, 32'ha5);
		@(posedge pclk);
		rd(ADDR_STAT, 32'h48);
		p.xfer(8'h3c, 1'b0, 8, rx);
		chk({24'h0, rx}, 32'ha5);
		p.xfer(8'h77, 1'b0, 8, rx);
		chk({24'h0, rx}, 32'h3c);
		rd(ADDR_STAT, 32'he8);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_DATA, 32'h3c);
		rd(ADDR_STAT, 32'h48);
	endtask
	task automatic t_ctrl();
		int n;
		p.tsh = 8'hc3;
		apb(1'b1, ADDR_CTRL, 32'h22);
		apb(1'b1, ADDR_DATA, 32'h11);
		@(posedge pclk);
		rd(ADDR_STAT, 32'h48);
		// 5a never appears in the partner while 11 is still shifting out ahead of it
		apb(1'b1, ADDR_DATA, 32'h5a);
		rd(ADDR_STAT, 32'h40);
		for (n = 0; n < 400 && p.rsh !== 8'h5a; n++) @(posedge pclk);
		chk({24'h0, p.rsh}, 32'h5a);
		if (n == 400) begin
			test_done();
		end
		rd(ADDR_STAT, 32'he8);
		rd(ADDR_DATA, 32'hc3);
		rd(ADDR_STAT, 32'h48);
	endtask
	task automatic t_fault();
		apb(1'b1, ADDR_STAT, 32'h44);
		p.ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(ADDR_CTRL, 32'h20);
		rd(ADDR_STAT, 32'h5c);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_CTRL, 32'h22);
		repeat (4) @(posedge pclk);
		rd(ADDR_STAT, 32'h5c);
		rd(ADDR_CTRL, 32'h20);
		p.ss_n <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b1, ADDR_CTRL, 32'h02);
		rd(ADDR_STAT, 32'h4c);
		sel_pulse();
		rd(ADDR_CTRL, 32'h02);
		rd(ADDR_STAT, 32'h5c);
		// the faulted target stays mid-transfer until software disables it
		apb(1'b1, ADDR_CTRL, 32'h00);
		apb(1'b1, ADDR_CTRL, 32'h0a);
		sel_pulse();
		rd(ADDR_STAT, 32'h4c);
		p.xfer(8'h00, 1'b1, 3, rx);
		apb(1'b1, ADDR_STAT, 32'h40);
		rd(ADDR_STAT, 32'h58);
		apb(1'b1, ADDR_CTRL, 32'h00);
		rd(ADDR_STAT, 32'h48);
	endtask
	task automatic t_mode3();
		p.tsh = 8'h81;
		apb(1'b1, ADDR_CTRL, 32'hba);
		apb(1'b1, ADDR_DATA, 32'h96);
		repeat (80) @(posedge pclk);
		chk({24'h0, p.rsh}, 32'h96);
		chk({31'h0, irq}, 32'h1);
		// detection is off, so a low select must leave the controller running
		p.ss_n <= 1'b0;
		repeat (8) @(posedge pclk);
		rd(ADDR_STAT, 32'hc8);
		rd(ADDR_CTRL, 32'hba);
		// the partner shifts on the first falling edge, so its own msb is gone before the first rising-edge sample
		rd(ADDR_DATA, 32'h02);
		chk({31'h0, irq}, 32'h0);
		p.ss_n <= 1'b1;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_target();
		t_ctrl();
		t_fault();
		t_mode3();
		test_done();
	end
endmodule
`default_nettype wire
